/* File: common/fscg_defs.svh */
// Register indices, field positions and reset values of the frame sync unit
`ifndef FSCG_DEFS_SVH
`define FSCG_DEFS_SVH
// ****************************************
// Register indices
// ****************************************
`define FSCG_IDX_SYNC 3'h0
`define FSCG_IDX_A0 3'h1
`define FSCG_IDX_A1 3'h2
`define FSCG_IDX_B0 3'h3
`define FSCG_IDX_B1 3'h4
`define FSCG_IDX_PW 3'h5
`define FSCG_IDX_STAT 3'h6
`define FSCG_IDX_LAST_CFG 3'h5
// ****************************************
// Field positions
// ****************************************
`define FSCG_EN_CLK 31
`define FSCG_EN_FS 30
`define FSCG_CLK_SRC 31
`define FSCG_FS_SRC 30
`define FSCG_PH_MSB 29
`define FSCG_PH_LSB 20
`define FSCG_DIV_MSB 19
`define FSCG_UNIT_STRIDE 16
`define FSCG_SYNC_FS 0
`define FSCG_SYNC_CLK 1
`define FSCG_STROBE 0
`define FSCG_INV 1
// ****************************************
// Values
// ****************************************
`define FSCG_RST_WORD 32'h0000_0000
`define FSCG_TRIG_PHASE 20'h00003
`define FSCG_DIV_ONE 20'h00001
`define FSCG_CNT_ZERO 20'h00000
`define FSCG_PW_ZERO 16'h0000
`endif

/* File: common/fscg_pkg.sv */
// Types shared by both ends of the frame sync unit
package fscg_pkg;
  typedef logic [2:0] fscg_idx_t;
  typedef logic [31:0] fscg_word_t;
  // One-shot strobe sequencer
  typedef enum logic [1:0] {
    OS_WAIT = 2'b00,
    OS_FIRST = 2'b01,
    OS_SECOND = 2'b10,
    OS_PULSE = 2'b11
  } fscg_os_e;
  // Programming sequencer
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_CFG = 3'b001,
    H_EN_A = 3'b010,
    H_EN_B = 3'b011,
    H_DIS_A = 3'b100,
    H_DIS_B = 3'b101
  } fscg_hs_e;
endpackage

/* File: common/fscg_reg_if.sv */
// Register write and read port between programmer and frame sync unit
`timescale 1ns/1ps
`default_nettype none
interface fscg_reg_if (
  input wire logic clock,
  input wire logic arst_n
);
  logic wr_en;
  logic [2:0] wr_idx;
  logic [31:0] wr_data;
  logic [2:0] rd_idx;
  logic [31:0] rd_data;
  modport dev (
    input clock, arst_n, wr_en, wr_idx, wr_data, rd_idx,
    output rd_data
  );
  modport prog (
    input clock, arst_n, rd_data,
    output wr_en, wr_idx, wr_data, rd_idx
  );
endinterface
`default_nettype wire

/* File: core/fscg_device.sv */
// Frame sync and clock generator, two units, with its register file
//
// Overview of operation
// - Sync bit 0/16 arms frame trigger start
// - Software sets phase 3 in trigger mode
// - No frame sync until trigger rising edge
// - Later trigger edges are ignored
// - Configure registers first, then set enables
// - Sync bit 1/17 starts clock on trigger
// - Divisor bits 19-0; below two means bypass
// - Normal period equals divisor cycles of clock
// - Phase split: upper in word0, lower word1
// - Software keeps phase below divisor
// - Phase N leads clock by N cycles
// - Alignment needs same source, write, multiple
// - Pair enabled and disabled in one write
// - Width field sets normal high time
// - Zero width gives half divisor, rounded down
// - Strobe bit picks pass-through or one-shot
// - Active-low bit sets bypass output polarity
// - Other width bits ignored in bypass
// - Pass-through copies input, optionally inverted
// - One-shot: second timing rise, one period
// - Word1 bit 31 selects clock source
// - Odd clock divisor: low one cycle longer
`timescale 1ns/1ps
`default_nettype none
`include "fscg_defs.svh"
module fscg_device #(
  parameter int UNITS = 2,
  parameter int DIV_W = 20
) (
  input wire logic clock,
  input wire logic arst_n,
  fscg_reg_if.dev bus,
  input wire logic osc_in,
  input wire logic routed_in,
  input wire logic [1:0] external_trigger_in,
  input wire logic strobe_timing_in_a,
  input wire logic strobe_timing_in_b,
  output logic [1:0] clk_out,
  output logic [1:0] fs_out
);
  import fscg_pkg::*;

  // Refuse sizes that the fixed field map cannot serve
  if (UNITS != 2 || DIV_W != 20) begin : g_size_check
    $error("fscg_device supports two units with 20-bit divisors only");
  end

  // ****************************************
  // Register file
  // ****************************************
  fscg_word_t sync_q, sync_d;
  fscg_word_t pw_q, pw_d;
  fscg_word_t ctl0_q [2];
  fscg_word_t ctl0_d [2];
  fscg_word_t ctl1_q [2];
  fscg_word_t ctl1_d [2];
  fscg_word_t rd_q, rd_d;
  logic [1:0] fs_go_q;
  logic [1:0] clk_go_q;

  // Decode whether an index hits word0 or word1 of a unit
  function automatic logic fscg_hit(input fscg_idx_t idx,
                                    input fscg_idx_t base, input int u);
    fscg_idx_t tgt;
    tgt = 3'(base + 3'(2 * u));
    return idx == tgt;
  endfunction

  // Next register values from the write port
  always_comb begin
    sync_d = sync_q;
    pw_d = pw_q;
    for (int u = 0; u < 2; u++) begin
      ctl0_d[u] = ctl0_q[u];
      ctl1_d[u] = ctl1_q[u];
      if (bus.wr_en && fscg_hit(bus.wr_idx, `FSCG_IDX_A0, u)) begin
        ctl0_d[u] = bus.wr_data;
      end
      if (bus.wr_en && fscg_hit(bus.wr_idx, `FSCG_IDX_A1, u)) begin
        ctl1_d[u] = bus.wr_data;
      end
    end
    if (bus.wr_en && bus.wr_idx == `FSCG_IDX_SYNC) begin
      sync_d = bus.wr_data;
    end
    if (bus.wr_en && bus.wr_idx == `FSCG_IDX_PW) begin
      pw_d = bus.wr_data;
    end
    case (bus.rd_idx)
      `FSCG_IDX_SYNC: rd_d = sync_q;
      `FSCG_IDX_A0: rd_d = ctl0_q[0];
      `FSCG_IDX_A1: rd_d = ctl1_q[0];
      `FSCG_IDX_B0: rd_d = ctl0_q[1];
      `FSCG_IDX_B1: rd_d = ctl1_q[1];
      `FSCG_IDX_PW: rd_d = pw_q;
      `FSCG_IDX_STAT: rd_d = {28'h0000000, clk_go_q, fs_go_q};
      default: rd_d = `FSCG_RST_WORD;
    endcase
  end

  // Register storage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync_q <= `FSCG_RST_WORD;
      pw_q <= `FSCG_RST_WORD;
      rd_q <= `FSCG_RST_WORD;
      for (int u = 0; u < 2; u++) begin
        ctl0_q[u] <= `FSCG_RST_WORD;
        ctl1_q[u] <= `FSCG_RST_WORD;
      end
    end else begin
      sync_q <= sync_d;
      pw_q <= pw_d;
      rd_q <= rd_d;
      for (int u = 0; u < 2; u++) begin
        ctl0_q[u] <= ctl0_d[u];
        ctl1_q[u] <= ctl1_d[u];
      end
    end
  end

  assign bus.rd_data = rd_q;

  // ****************************************
  // Generator units
  // ****************************************
  logic [1:0] timing_in;
  assign timing_in = {strobe_timing_in_b, strobe_timing_in_a};

  for (genvar i = 0; i < 2; i++) begin : g_unit
    logic [19:0] fs_div, clk_div, phase, fcnt_q, fcnt_d, ccnt_q, ccnt_d;
    logic [19:0] width, start;
    logic [15:0] pw_field;
    logic en_fs, en_clk, src, strobe, inv, trig_fs, trig_clk;
    logic sel_in, sel_prev_q, trig_prev_q, tim_prev_q;
    logic trig_rise, ck_edge, tim_rise, bypass_fs, bypass_clk;
    logic fs_go_d, clk_go_d, fs_d, clk_d, fs_q, clk_q;
    fscg_os_e os_q, os_d;

    // Field extraction
    assign fs_div = ctl0_q[i][`FSCG_DIV_MSB:0];
    assign clk_div = ctl1_q[i][`FSCG_DIV_MSB:0];
    assign phase = {ctl0_q[i][`FSCG_PH_MSB:`FSCG_PH_LSB],
                    ctl1_q[i][`FSCG_PH_MSB:`FSCG_PH_LSB]};
    assign en_clk = ctl0_q[i][`FSCG_EN_CLK];
    assign en_fs = ctl0_q[i][`FSCG_EN_FS];
    assign src = ctl1_q[i][`FSCG_CLK_SRC];
    assign pw_field = pw_q[`FSCG_UNIT_STRIDE*i +: `FSCG_UNIT_STRIDE];
    assign strobe = pw_q[`FSCG_UNIT_STRIDE*i + `FSCG_STROBE];
    assign inv = pw_q[`FSCG_UNIT_STRIDE*i + `FSCG_INV];
    assign trig_fs = sync_q[`FSCG_UNIT_STRIDE*i + `FSCG_SYNC_FS];
    assign trig_clk = sync_q[`FSCG_UNIT_STRIDE*i + `FSCG_SYNC_CLK];

    // Source select and edge detection
    assign sel_in = src ? routed_in : osc_in;
    assign trig_rise = external_trigger_in[i] & ~trig_prev_q;
    assign ck_edge = inv ? (sel_prev_q & ~sel_in) : (~sel_prev_q & sel_in);
    assign tim_rise = timing_in[i] & ~tim_prev_q;
    assign bypass_fs = fs_div <= `FSCG_DIV_ONE;
    assign bypass_clk = clk_div <= `FSCG_DIV_ONE;

    // Width: zero selects half divisor; only normal mode reads it
    assign width = (pw_field == `FSCG_PW_ZERO) ? (fs_div >> 1)
                 : {4'h0, pw_field};
    // Counter start lets frame sync lead clock by phase cycles
    assign start = (phase < fs_div) ? phase : `FSCG_CNT_ZERO;

    // Next state of counters, trigger gates and outputs
    always_comb begin
      fs_go_d = en_fs & (fs_go_q[i] | ~trig_fs | trig_rise);
      clk_go_d = en_clk & (clk_go_q[i] | ~trig_clk | trig_rise);
      fcnt_d = start;
      ccnt_d = `FSCG_CNT_ZERO;
      os_d = OS_WAIT;
      fs_d = bypass_fs & inv & strobe;
      clk_d = 1'b0;
      if (fs_go_q[i] && !bypass_fs) begin
        fcnt_d = (fcnt_q >= 20'(fs_div - `FSCG_DIV_ONE)) ? `FSCG_CNT_ZERO
               : 20'(fcnt_q + `FSCG_DIV_ONE);
        fs_d = fcnt_q < width;
      end else if (fs_go_q[i] && !strobe) begin
        fs_d = sel_in ^ inv;
      end else if (fs_go_q[i]) begin
        case (os_q)
          OS_WAIT: os_d = !ck_edge ? OS_WAIT
                        : (tim_rise ? OS_SECOND : OS_FIRST);
          OS_FIRST: os_d = tim_rise ? OS_SECOND : OS_FIRST;
          OS_SECOND: os_d = tim_rise ? OS_PULSE : OS_SECOND;
          OS_PULSE: os_d = tim_rise ? OS_WAIT : OS_PULSE;
          default: os_d = OS_WAIT;
        endcase
        fs_d = (os_d == OS_PULSE) ^ inv;
      end
      if (clk_go_q[i] && bypass_clk) begin
        clk_d = sel_in;
      end else if (clk_go_q[i]) begin
        ccnt_d = (ccnt_q >= 20'(clk_div - `FSCG_DIV_ONE)) ? `FSCG_CNT_ZERO
               : 20'(ccnt_q + `FSCG_DIV_ONE);
        clk_d = ccnt_q < (clk_div >> 1);
      end
    end

    // Unit state registers
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        fcnt_q <= `FSCG_CNT_ZERO;
        ccnt_q <= `FSCG_CNT_ZERO;
        os_q <= OS_WAIT;
        fs_go_q[i] <= 1'b0;
        clk_go_q[i] <= 1'b0;
        fs_q <= 1'b0;
        clk_q <= 1'b0;
        sel_prev_q <= 1'b0;
        trig_prev_q <= 1'b0;
        tim_prev_q <= 1'b0;
      end else begin
        fcnt_q <= fcnt_d;
        ccnt_q <= ccnt_d;
        os_q <= os_d;
        fs_go_q[i] <= fs_go_d;
        clk_go_q[i] <= clk_go_d;
        fs_q <= fs_d;
        clk_q <= clk_d;
        sel_prev_q <= sel_in;
        trig_prev_q <= external_trigger_in[i];
        tim_prev_q <= timing_in[i];
      end
    end

    assign fs_out[i] = fs_q;
    assign clk_out[i] = clk_q;
  end
endmodule
`default_nettype wire

/* File: core/fscg_programmer.sv */
// Programming end: writes configuration in order, then enables with one write per unit, A then B
`timescale 1ns/1ps
`default_nettype none
`include "fscg_defs.svh"
module fscg_programmer (
  input wire logic clock,
  input wire logic arst_n,
  fscg_reg_if.prog bus,
  input wire logic [31:0] cfg_sync,
  input wire logic [31:0] cfg_a0,
  input wire logic [31:0] cfg_a1,
  input wire logic [31:0] cfg_b0,
  input wire logic [31:0] cfg_b1,
  input wire logic [31:0] cfg_pw,
  input wire logic start,
  input wire logic stop,
  input wire fscg_pkg::fscg_idx_t rd_sel,
  output logic [31:0] rd_value,
  output logic busy,
  output logic cfg_error
);
  import fscg_pkg::*;

  // ****************************************
  // Configuration repair
  // ****************************************
  // Phase: 3 under trigger start, else kept below the divisor
  function automatic logic [19:0] fscg_fix_phase(input fscg_word_t c0,
      input fscg_word_t c1, input logic trig);
    logic [19:0] ph, dv;
    ph = {c0[`FSCG_PH_MSB:`FSCG_PH_LSB], c1[`FSCG_PH_MSB:`FSCG_PH_LSB]};
    dv = c0[`FSCG_DIV_MSB:0];
    if (trig) begin
      ph = `FSCG_TRIG_PHASE;
    end else if (dv > `FSCG_DIV_ONE && ph >= dv) begin
      ph = 20'(dv - `FSCG_DIV_ONE);
    end
    return ph;
  endfunction

  // Pair that cannot be phase aligned
  function automatic logic fscg_pair_bad(input fscg_word_t c0,
                                         input fscg_word_t c1);
    logic [19:0] fd, cd;
    fd = c0[`FSCG_DIV_MSB:0];
    cd = c1[`FSCG_DIV_MSB:0];
    fscg_pair_bad = c0[`FSCG_EN_CLK] && c0[`FSCG_EN_FS] &&
      fd > `FSCG_DIV_ONE && cd > `FSCG_DIV_ONE &&
      ((fd % cd) != `FSCG_CNT_ZERO ||
       c1[`FSCG_CLK_SRC] != c1[`FSCG_FS_SRC]);
  endfunction

  logic [19:0] ph_a, ph_b;
  fscg_word_t a0_fix, a1_fix, b0_fix, b1_fix;
  assign ph_a = fscg_fix_phase(cfg_a0, cfg_a1, cfg_sync[`FSCG_SYNC_FS]);
  assign ph_b = fscg_fix_phase(cfg_b0, cfg_b1,
                  cfg_sync[`FSCG_UNIT_STRIDE + `FSCG_SYNC_FS]);
  // Words with enables cleared and repaired phase
  assign a0_fix = {2'b00, ph_a[19:10], cfg_a0[`FSCG_DIV_MSB:0]};
  assign a1_fix = {cfg_a1[31:30], ph_a[9:0], cfg_a1[`FSCG_DIV_MSB:0]};
  assign b0_fix = {2'b00, ph_b[19:10], cfg_b0[`FSCG_DIV_MSB:0]};
  assign b1_fix = {cfg_b1[31:30], ph_b[9:0], cfg_b1[`FSCG_DIV_MSB:0]};

  // ****************************************
  // Sequencer
  // ****************************************
  fscg_hs_e st_q, st_d;
  fscg_idx_t idx_q, idx_d;
  logic wr_en_q, wr_en_d, err_q, err_d;
  fscg_idx_t wr_idx_q, wr_idx_d;
  fscg_word_t wr_data_q, wr_data_d, rd_q;

  // Next sequencer state and write port values
  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    err_d = err_q;
    wr_en_d = 1'b0;
    wr_idx_d = wr_idx_q;
    wr_data_d = wr_data_q;
    case (st_q)
      H_IDLE: begin
        idx_d = `FSCG_IDX_SYNC;
        if (start) begin
          st_d = H_CFG;
          err_d = fscg_pair_bad(cfg_a0, cfg_a1) ||
                  fscg_pair_bad(cfg_b0, cfg_b1);
        end else if (stop) begin
          st_d = H_DIS_A;
        end
      end
      H_CFG: begin
        wr_en_d = 1'b1;
        wr_idx_d = idx_q;
        case (idx_q)
          `FSCG_IDX_SYNC: wr_data_d = cfg_sync;
          `FSCG_IDX_A0: wr_data_d = a0_fix;
          `FSCG_IDX_A1: wr_data_d = a1_fix;
          `FSCG_IDX_B0: wr_data_d = b0_fix;
          `FSCG_IDX_B1: wr_data_d = b1_fix;
          default: wr_data_d = cfg_pw;
        endcase
        idx_d = 3'(idx_q + 3'h1);
        if (idx_q == `FSCG_IDX_LAST_CFG) begin
          st_d = H_EN_A;
        end
      end
      H_EN_A: begin
        wr_en_d = 1'b1;
        wr_idx_d = `FSCG_IDX_A0;
        wr_data_d = {cfg_a0[31:30], a0_fix[29:0]};
        st_d = H_EN_B;
      end
      H_EN_B: begin
        wr_en_d = 1'b1;
        wr_idx_d = `FSCG_IDX_B0;
        wr_data_d = {cfg_b0[31:30], b0_fix[29:0]};
        st_d = H_IDLE;
      end
      H_DIS_A: begin
        wr_en_d = 1'b1;
        wr_idx_d = `FSCG_IDX_A0;
        wr_data_d = a0_fix;
        st_d = H_DIS_B;
      end
      H_DIS_B: begin
        wr_en_d = 1'b1;
        wr_idx_d = `FSCG_IDX_B0;
        wr_data_d = b0_fix;
        st_d = H_IDLE;
      end
      default: st_d = H_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= H_IDLE;
      idx_q <= `FSCG_IDX_SYNC;
      err_q <= 1'b0;
      wr_en_q <= 1'b0;
      wr_idx_q <= `FSCG_IDX_SYNC;
      wr_data_q <= `FSCG_RST_WORD;
      rd_q <= `FSCG_RST_WORD;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      err_q <= err_d;
      wr_en_q <= wr_en_d;
      wr_idx_q <= wr_idx_d;
      wr_data_q <= wr_data_d;
      rd_q <= bus.rd_data;
    end
  end

  assign bus.wr_en = wr_en_q;
  assign bus.wr_idx = wr_idx_q;
  assign bus.wr_data = wr_data_q;
  assign bus.rd_idx = rd_sel;
  assign rd_value = rd_q;
  assign busy = (st_q != H_IDLE) || wr_en_q;
  assign cfg_error = err_q;
endmodule
`default_nettype wire

/* File: tb/fscg_assertions.sv */
// Concurrent checks on the register port between programmer and device
`timescale 1ns/1ps
`default_nettype none
module fscg_assertions (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic [2:0] rd_idx,
  input wire logic [31:0] rd_data
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ****************************************
  // Write sequences
  // ****************************************
  // Configuration words with both enables still clear
  sequence cfg_burst_s;
    wr_en && wr_idx == 3'h1 && wr_data[31:30] == 2'h0 ##1
    wr_en && wr_idx == 3'h2 ##1
    wr_en && wr_idx == 3'h3 && wr_data[31:30] == 2'h0 ##1
    wr_en && wr_idx == 3'h4 ##1 wr_en && wr_idx == 3'h5;
  endsequence
  // Enable words of both units, then the port falls quiet
  sequence enable_pair_s;
    wr_en && wr_idx == 3'h1 ##1 wr_en && wr_idx == 3'h3 ##1 !wr_en;
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  cfg_order_a: assert property (
    wr_en && wr_idx == 3'h0 |=> cfg_burst_s ##1 enable_pair_s)
    else $error("configuration write order broken");
  store_read_a: assert property (
    wr_en && wr_idx <= 3'h5 && rd_idx == wr_idx ##1 $stable(rd_idx)
    |=> rd_data == $past(wr_data, 2))
    else $error("written word not read back");
  unmapped_read_a: assert property (
    rd_idx == 3'h7 ##1 rd_idx == 3'h7 |-> rd_data == 32'h0)
    else $error("unmapped index reads nonzero");
  trig_phase_a: assert property (
    wr_en && wr_idx == 3'h2 && $past(wr_en, 2) && $past(wr_idx, 2) == 3'h0
    && $past(wr_data[0], 2) |-> wr_data[29:20] == 10'h003
    && $past(wr_data[29:20]) == 10'h000)
    else $error("unit A trigger phase not three");
  trig_phase_b_a: assert property (
    wr_en && wr_idx == 3'h4 && $past(wr_en, 4) && $past(wr_idx, 4) == 3'h0
    && $past(wr_data[16], 4) |-> wr_data[29:20] == 10'h003
    && $past(wr_data[29:20]) == 10'h000)
    else $error("unit B trigger phase not three");
  phase_range_a: assert property (
    wr_en && wr_idx == 3'h2 && $past(wr_en) && $past(wr_idx) == 3'h1
    && !$past(wr_data[0], 2) && $past(wr_data[19:0]) > 20'h1
    |-> {$past(wr_data[29:20]), wr_data[29:20]} < $past(wr_data[19:0]))
    else $error("phase not below divisor");
  disable_pair_a: assert property (
    wr_en && wr_idx == 3'h1 && !$past(wr_en) |-> wr_data[31:30] == 2'h0
    ##1 wr_en && wr_idx == 3'h3 && wr_data[31:30] == 2'h0 ##1 !wr_en)
    else $error("disable not done as one pair");
  pair_end_a: assert property (
    wr_en && wr_idx == 3'h3 && $past(wr_en) && $past(wr_idx) == 3'h1
    |=> !wr_en)
    else $error("extra write after enable pair");
endmodule
`default_nettype wire

/* File: tb/frame_sync_clock_generator_tb_top.sv */
// Bench joining programmer and device over the register port
`timescale 1ns/1ps
`default_nettype none
module frame_sync_clock_generator_tb_top;
  import fscg_pkg::*;
  logic clock, arst_n, osc_in, routed_in, stb_a, stb_b, start, stop;
  logic busy, cfg_error;
  logic [1:0] trig, clk_out, fs_out;
  logic [3:0] outs;
  logic [31:0] cfg [6];
  logic [31:0] rd_value;
  fscg_idx_t rd_sel;
  int fail_count, total_checks, p, h, n, t0, cyc;
  assign outs = {clk_out, fs_out};
  fscg_reg_if bus (.clock(clock), .arst_n(arst_n));
  fscg_device i_fscg_device (.clock(clock), .arst_n(arst_n), .bus(bus),
    .osc_in(osc_in), .routed_in(routed_in), .external_trigger_in(trig),
    .strobe_timing_in_a(stb_a), .strobe_timing_in_b(stb_b),
    .clk_out(clk_out), .fs_out(fs_out));
  fscg_programmer i_fscg_programmer (.clock(clock), .arst_n(arst_n),
    .bus(bus), .cfg_sync(cfg[0]), .cfg_a0(cfg[1]), .cfg_a1(cfg[2]),
    .cfg_b0(cfg[3]), .cfg_b1(cfg[4]), .cfg_pw(cfg[5]), .start(start),
    .stop(stop), .rd_sel(rd_sel), .rd_value(rd_value), .busy(busy),
    .cfg_error(cfg_error));
  fscg_assertions i_fscg_assertions (.clock(clock), .arst_n(arst_n),
    .wr_en(bus.wr_en), .wr_idx(bus.wr_idx), .wr_data(bus.wr_data),
    .rd_idx(bus.rd_idx), .rd_data(bus.rd_data));
  // ****************************************
  // Clock, cycle count, watchdog
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Free cycle count for spacing checks
  always_ff @(posedge clock) cyc <= cyc + 1;
  // Cuts a hang short
  initial begin
    repeat (4000) @(posedge clock);
    fail_count++;
    $display("[ERR] watchdog expected done seen hang");
    summarize();
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Pulse start or stop, wait for the sequencer to finish
  task automatic kick(input logic is_stop);
    int k;
    start = !is_stop;
    stop = is_stop;
    @(negedge clock);
    start = 1'b0;
    stop = 1'b0;
    k = 0;
    while (busy !== 1'b0 && k < 50) begin
      @(negedge clock);
      k++;
    end
    check("busy", busy, 1'b0);
  endtask
  task automatic configure(input logic [31:0] s, a0, a1, b0, b1, pw);
    cfg = '{s, a0, a1, b0, b1, pw};
    kick(1'b0);
    repeat (3) @(negedge clock);
  endtask
  // Stop both units, outputs must then stay low
  task automatic halt();
    int k;
    kick(1'b1);
    repeat (4) @(negedge clock);
    k = 0;
    repeat (16) begin
      @(negedge clock);
      if (outs !== 4'h0) k++;
    end
    check("idle", k, 0);
  endtask
  task automatic read_reg(input fscg_idx_t idx, input logic [31:0] exp);
    rd_sel = idx;
    repeat (4) @(negedge clock);
    check("read", rd_value, exp);
  endtask
  // Period and high time of one output, ends at a rising edge
  task automatic measure(input int s, output int per, output int hi);
    int k;
    k = 0;
    while (outs[s] !== 1'b0 && k < 100) begin
      @(negedge clock);
      k++;
    end
    while (outs[s] !== 1'b1 && k < 100) begin
      @(negedge clock);
      k++;
    end
    hi = 0;
    per = 0;
    while (outs[s] === 1'b1 && per < 100) begin
      @(negedge clock);
      hi++;
      per++;
    end
    while (outs[s] === 1'b0 && per < 100) begin
      @(negedge clock);
      per++;
    end
  endtask
  // Bypass pass-through from either source
  task automatic pass_thru(input logic r, input logic inv);
    logic last;
    configure(0, 32'h4000_0001, {r, 31'h0}, 0, 0, {30'h3FFF, inv, 1'b0});
    last = r ? routed_in : osc_in;
    for (int i = 0; i < 12; i++) begin
      @(negedge clock);
      check("bypass", fs_out[0], last ^ inv);
      last = i[0] ^ i[2];
      routed_in = r ? last : ~last;
      osc_in = r ? ~last : last;
    end
    halt();
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    arst_n = 1'b0;
    {osc_in, routed_in, stb_a, stb_b, start, stop} = 6'h00;
    trig = 2'h0;
    cfg = '{default: 32'h0};
    rd_sel = 3'h0;
    repeat (5) @(negedge clock);
    arst_n = 1'b1;
    read_reg(3'h5, 32'h0);
    // Normal mode on both units
    configure(0, 32'hC000_0008, 32'h8, 32'hC000_0007, 32'h7, 32'h3);
    check("cfg_error", cfg_error, 1'b0);
    measure(0, p, h);
    check("clk_a", clk_out[0], 1'b1);
    check("fs_a_per", p, 8);
    check("fs_a_hi", h, 3);
    measure(1, p, h);
    check("fs_b_per", p, 7);
    check("fs_b_hi", h, 3);
    measure(3, p, h);
    check("clk_b_hi", h, 3);
    check("clk_b_lo", p - h, 4);
    read_reg(3'h1, 32'hC000_0008);
    read_reg(3'h4, 32'h7);
    read_reg(3'h7, 32'h0);
    halt();
    // Trigger start of frame and clock on unit A
    configure(32'h3, 32'hC000_0008, 32'h8, 0, 0, 32'h3);
    n = 0;
    repeat (20) begin
      @(negedge clock);
      if (outs[0] !== 1'b0 || outs[2] !== 1'b0) n++;
    end
    check("pre_trigger", n, 0);
    trig[0] = 1'b1;
    measure(0, p, h);
    t0 = cyc;
    check("trig_per", p, 8);
    n = 0;
    while (clk_out[0] !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    check("lead", n, 3);
    trig[0] = 1'b0;
    repeat (2) @(negedge clock);
    trig[0] = 1'b1;
    measure(0, p, h);
    check("retrigger", cyc - t0, 16);
    halt();
    trig[0] = 1'b0;
    pass_thru(1'b0, 1'b1);
    pass_thru(1'b1, 1'b0);
    // One-shot strobe on unit A, timed by its timing input
    osc_in = 1'b0;
    configure(0, 32'h4000_0001, 0, 0, 0, 32'h1);
    n = 0;
    p = -1;
    for (int i = 0; i < 16; i++) begin
      osc_in = (i > 0);
      stb_a = i[1];
      @(negedge clock);
      if (fs_out[0] === 1'b1) begin
        n++;
        if (p < 0) p = i;
      end
    end
    check("strobe_len", n, 4);
    check("strobe_start", p, 6);
    halt();
    summarize();
  end
endmodule
`default_nettype wire
